// >>> core/dmx_pkg.sv
/*
  Shared constants, types and register map for the data-move executor.
  Assumes a single clock domain and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package dmx_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_INSTR   = 8'h00;
  localparam logic [7:0] OFS_ACC     = 8'h04;
  localparam logic [7:0] OFS_BANK    = 8'h08;
  localparam logic [7:0] OFS_PCLATCH = 8'h0c;
  localparam logic [7:0] OFS_OPTION  = 8'h10;
  localparam logic [7:0] OFS_PTR0    = 8'h14;
  localparam logic [7:0] OFS_PTR1    = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_EADDR   = 8'h20;
  localparam logic [7:0] OFS_MEMADDR = 8'h24;
  localparam logic [7:0] OFS_MEMDATA = 8'h28;
  localparam logic [7:0] OFS_ICOUNT  = 8'h2c;
  localparam logic [7:0] PTR_STRIDE  = 8'h04;
  // Values after reset.
  localparam logic [7:0]  RST_ACC     = 8'h00;
  localparam logic [4:0]  RST_BANK    = 5'h00;
  localparam logic [6:0]  RST_PCLATCH = 7'h00;
  localparam logic [7:0]  RST_OPTION  = 8'hff;
  localparam logic [15:0] RST_PTR     = 16'h0000;
  localparam logic [7:0]  RST_STATUS  = 8'h00;
  // Instruction word layout.
  localparam int INSTR_W  = 14;
  localparam int OPC_LSB  = 11;
  localparam int BANK_W   = 5;
  localparam int PCL_W    = 7;
  localparam int FADDR_W  = 7;
  localparam int OFS_W    = 6;
  localparam int PTR_W    = 16;
  localparam int KPTR_BIT = 6;
  localparam int MPTR_BIT = 2;
  // File addresses that stand for the two pointers' targets.
  localparam logic [6:0] FADDR_IND0 = 7'h00;
  localparam logic [6:0] FADDR_IND1 = 7'h01;
  // Indirect mode field codes.
  localparam logic [1:0] MODE_PREINC  = 2'b00;
  localparam logic [1:0] MODE_PREDEC  = 2'b01;
  localparam logic [1:0] MODE_POSTINC = 2'b10;
  localparam logic [1:0] MODE_POSTDEC = 2'b11;

  typedef enum logic [2:0] {
    OP_NOP    = 3'b000,
    OP_BANK   = 3'b001,
    OP_PCLAT  = 3'b010,
    OP_ACCLIT = 3'b011,
    OP_STORE  = 3'b100,
    OP_OPTION = 3'b101,
    OP_INDM   = 3'b110,
    OP_INDK   = 3'b111
  } dmx_op_e;

  typedef struct packed {
    dmx_op_e    op;
    logic [7:0] lit;
    logic       ptr;
    logic [1:0] mode;
    logic [5:0] ofs;
  } dmx_dec_s;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } dmx_mwr_s;
endpackage
`default_nettype wire

// >>> core/dmx_decode.sv
/*
  Instruction field decoder for the data-move executor.
  Assumes a 14-bit instruction word with the class code in the top bits.
*/
`default_nettype none
module dmx_decode (
  input  wire logic [13:0]       instr,
  output dmx_pkg::dmx_dec_s      dec
);
  always_comb
  begin
    dec.op   = dmx_pkg::dmx_op_e'(instr[13:dmx_pkg::OPC_LSB]);
    dec.lit  = instr[7:0];
    dec.mode = instr[1:0];
    dec.ofs  = instr[dmx_pkg::OFS_W-1:0];
    if (dec.op == dmx_pkg::OP_INDK)
    begin
      dec.ptr = instr[dmx_pkg::KPTR_BIT];
    end
    else
    begin
      dec.ptr = instr[dmx_pkg::MPTR_BIT];
    end
  end
endmodule
`default_nettype wire

// >>> core/dmx_file_mem.sv
/*
  File register storage with one write port and a registered read port.
  Assumes a single clock; contents are not reset.
*/
`default_nettype none
module dmx_file_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (we)
      begin
        mem_q[waddr] <= wdata;
      end
      rdata <= mem_q[raddr];
    end
  end
endmodule
`default_nettype wire

// >>> core/dmx_exec.sv
/*
  Data-move instruction executor with an AHB-Lite register slave.
  Assumes one clock, hclk, and that the bus master issues single word
  transfers; an instruction written to the instruction register runs
  in the data phase of that write.
*/
`default_nettype none
// How it works
// - The bank literal load puts its operand into the bank selector and touches no flag.
// - The latch literal load puts its seven-bit operand into the pc high latch and touches no flag.
// - The accumulator literal load puts its eight-bit operand into the accumulator in one cycle.
// - The store copies the accumulator to the file register at a seven-bit address.
// - The option load copies the accumulator into the option register in one cycle.
// - The indirect store writes the accumulator through one of two pointers chosen by one bit.
// - Its address is the pointer, pointer plus one, minus one, or pointer plus a signed offset of -32 to 31.
// - Afterwards the pointer has gained one, lost one, or stays put in offset mode.
// - Mode 00 and 01 change the pointer before the access, 10 and 11 after it.
// - Addressing an indirect access register reaches the location its pointer holds.
// - Pointers are sixteen bits and wrap at both ends.
// - Pointer stepping never alters any status flag.
module dmx_exec #(
  parameter int AW = 7
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic      [4:0]  bank_selector,
  output logic      [6:0]  pc_high_latch,
  output logic      [7:0]  option_cfg
);
  logic [7:0]           acc_q;
  logic [4:0]           bank_q;
  logic [6:0]           pclatch_q;
  logic [7:0]           option_q;
  logic [15:0]          ptr_q [2];
  logic [7:0]           status_q;
  logic [15:0]          eaddr_q;
  logic [AW-1:0]        memaddr_q;
  logic [15:0]          icount_q;
  logic                 dp_wr_q;
  logic                 dp_rd_q;
  logic [7:0]           dp_addr_q;
  logic                 rd_wait_q;
  logic [31:0]          hrdata_q;
  logic [31:0]          rd_val;
  logic [7:0]           mem_rdata;
  logic                 ap_valid;
  logic                 sw_wr;
  logic                 exec;
  logic [15:0]          ptr_cur;
  logic [15:0]          ptr_inc;
  logic [15:0]          ptr_dec;
  logic [15:0]          ptr_nxt;
  dmx_pkg::dmx_dec_s    dec;
  dmx_pkg::dmx_mwr_s    mwr;

  dmx_decode u_decode (
    .instr (hwdata[dmx_pkg::INSTR_W-1:0]),
    .dec   (dec)
  );

  dmx_file_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .clk   (hclk),
    .ce    (ce),
    .we    (mwr.en),
    .waddr (mwr.addr[AW-1:0]),
    .wdata (mwr.data),
    .raddr (memaddr_q),
    .rdata (mem_rdata)
  );

  // Address phase is taken on an active transfer while the bus is ready.
  assign ap_valid  = hsel && hready && htrans[1];
  assign hreadyout = ce && !dp_rd_q && !rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign sw_wr     = ce && dp_wr_q;
  // An instruction runs in the single data-phase cycle of its write.
  assign exec      = sw_wr && (dp_addr_q == dmx_pkg::OFS_INSTR);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end
    else if (ce)
    begin
      if (hready)
      begin
        dp_wr_q   <= ap_valid && hwrite;
        dp_rd_q   <= ap_valid && !hwrite;
        dp_addr_q <= haddr[7:0];
      end
      else if (rd_wait_q)
      begin
        dp_rd_q <= 1'b0;
      end
    end
  end

  // Reads take two wait states so memory data behind a new address is
  // already settled when sampled.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_wait_q <= 1'b0;
      hrdata_q  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      rd_wait_q <= dp_rd_q && !rd_wait_q;
      if (rd_wait_q)
      begin
        hrdata_q <= rd_val;
      end
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (dp_addr_q)
      dmx_pkg::OFS_ACC:     rd_val = {24'h00_0000, acc_q};
      dmx_pkg::OFS_BANK:    rd_val = {27'h000_0000, bank_q};
      dmx_pkg::OFS_PCLATCH: rd_val = {25'h000_0000, pclatch_q};
      dmx_pkg::OFS_OPTION:  rd_val = {24'h00_0000, option_q};
      dmx_pkg::OFS_PTR0:    rd_val = {16'h0000, ptr_q[0]};
      dmx_pkg::OFS_PTR1:    rd_val = {16'h0000, ptr_q[1]};
      dmx_pkg::OFS_STATUS:  rd_val = {24'h00_0000, status_q};
      dmx_pkg::OFS_EADDR:   rd_val = {16'h0000, eaddr_q};
      dmx_pkg::OFS_MEMADDR: rd_val = 32'(memaddr_q);
      dmx_pkg::OFS_MEMDATA: rd_val = {24'h00_0000, mem_rdata};
      dmx_pkg::OFS_ICOUNT:  rd_val = {16'h0000, icount_q};
      default:              rd_val = 32'h0000_0000;
    endcase
  end

  // Pointer arithmetic wraps naturally in sixteen bits.
  always_comb
  begin
    ptr_cur = ptr_q[dec.ptr];
    ptr_inc = ptr_cur + 16'h0001;
    ptr_dec = ptr_cur - 16'h0001;
    if (dec.op == dmx_pkg::OP_INDK)
    begin
      ptr_nxt = ptr_cur;
    end
    else if (dec.mode[0])
    begin
      ptr_nxt = ptr_dec;
    end
    else
    begin
      ptr_nxt = ptr_inc;
    end
  end

  always_comb
  begin
    mwr.en   = 1'b0;
    mwr.addr = 16'h0000;
    mwr.data = acc_q;
    if (exec)
    begin
      case (dec.op)
        dmx_pkg::OP_STORE:
        begin
          mwr.en = 1'b1;
          if (dec.lit[6:0] == dmx_pkg::FADDR_IND0)
          begin
            mwr.addr = ptr_q[0];
          end
          else if (dec.lit[6:0] == dmx_pkg::FADDR_IND1)
          begin
            mwr.addr = ptr_q[1];
          end
          else
          begin
            mwr.addr = {9'h000, dec.lit[6:0]};
          end
        end
        dmx_pkg::OP_INDM:
        begin
          mwr.en = 1'b1;
          case (dec.mode)
            dmx_pkg::MODE_PREINC:  mwr.addr = ptr_inc;
            dmx_pkg::MODE_PREDEC:  mwr.addr = ptr_dec;
            dmx_pkg::MODE_POSTINC: mwr.addr = ptr_cur;
            dmx_pkg::MODE_POSTDEC: mwr.addr = ptr_cur;
            default:               mwr.addr = ptr_cur;
          endcase
        end
        dmx_pkg::OP_INDK:
        begin
          mwr.en   = 1'b1;
          mwr.addr = ptr_cur + {{10{dec.ofs[5]}}, dec.ofs};
        end
        default:
        begin
          mwr.en = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_q <= dmx_pkg::RST_ACC;
    end
    else if (exec && dec.op == dmx_pkg::OP_ACCLIT)
    begin
      acc_q <= dec.lit;
    end
    else if (sw_wr && dp_addr_q == dmx_pkg::OFS_ACC)
    begin
      acc_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bank_q    <= dmx_pkg::RST_BANK;
      pclatch_q <= dmx_pkg::RST_PCLATCH;
      option_q  <= dmx_pkg::RST_OPTION;
    end
    else if (exec)
    begin
      if (dec.op == dmx_pkg::OP_BANK)
      begin
        bank_q <= dec.lit[dmx_pkg::BANK_W-1:0];
      end
      if (dec.op == dmx_pkg::OP_PCLAT)
      begin
        pclatch_q <= dec.lit[dmx_pkg::PCL_W-1:0];
      end
      if (dec.op == dmx_pkg::OP_OPTION)
      begin
        option_q <= acc_q;
      end
    end
    else if (sw_wr)
    begin
      if (dp_addr_q == dmx_pkg::OFS_BANK)
      begin
        bank_q <= hwdata[dmx_pkg::BANK_W-1:0];
      end
      if (dp_addr_q == dmx_pkg::OFS_PCLATCH)
      begin
        pclatch_q <= hwdata[dmx_pkg::PCL_W-1:0];
      end
      if (dp_addr_q == dmx_pkg::OFS_OPTION)
      begin
        option_q <= hwdata[7:0];
      end
    end
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_ptr
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        ptr_q[i] <= dmx_pkg::RST_PTR;
      end
      else if (exec && (dec.op == dmx_pkg::OP_INDM ||
                        dec.op == dmx_pkg::OP_INDK) &&
               dec.ptr == 1'(i))
      begin
        ptr_q[i] <= ptr_nxt;
      end
      else if (sw_wr && dp_addr_q ==
               dmx_pkg::OFS_PTR0 + 8'(i) * dmx_pkg::PTR_STRIDE)
      begin
        ptr_q[i] <= hwdata[dmx_pkg::PTR_W-1:0];
      end
    end
  end

  // Status flags change only by software; no instruction here writes them.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_q <= dmx_pkg::RST_STATUS;
    end
    else if (sw_wr && dp_addr_q == dmx_pkg::OFS_STATUS)
    begin
      status_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      eaddr_q   <= 16'h0000;
      memaddr_q <= '0;
      icount_q  <= 16'h0000;
    end
    else if (ce)
    begin
      if (mwr.en)
      begin
        eaddr_q <= mwr.addr;
      end
      if (exec)
      begin
        icount_q <= icount_q + 16'h0001;
      end
      if (sw_wr && dp_addr_q == dmx_pkg::OFS_MEMADDR)
      begin
        memaddr_q <= hwdata[AW-1:0];
      end
    end
  end

  assign bank_selector = bank_q;
  assign pc_high_latch = pclatch_q;
  assign option_cfg    = option_q;
endmodule
`default_nettype wire

// >>> tb/dmx_exec_checker.sv
/*
  Port checker for the data-move executor.
  Assumes it is bound to dmx_exec and that ce is held high.
*/
`default_nettype none
module dmx_exec_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [4:0]  bank_selector,
  input wire logic [6:0]  pc_high_latch,
  input wire logic [7:0]  option_cfg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wv_q;
  logic [7:0] wa_q;
  logic       tk;
  logic       in_d;
  logic [2:0] op;
  assign tk = hsel & hready & htrans[1] & ce;
  assign in_d = wv_q & hready & (wa_q == dmx_pkg::OFS_INSTR);
  assign op = hwdata[13:11];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wv_q <= 1'b0;
      wa_q <= 8'h00;
    end
    else if (hready)
    begin
      wv_q <= tk & hwrite;
      wa_q <= haddr[7:0];
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bank_load_a: assert property (
    in_d && op == 3'b001 |=> bank_selector == $past(hwdata[4:0]))
    else $error("bank literal not loaded");
  bank_hold_a: assert property (
    !(in_d && op == 3'b001) && !(wv_q && hready &&
    wa_q == dmx_pkg::OFS_BANK) |=> $stable(bank_selector))
    else $error("bank selector changed");
  latch_load_a: assert property (
    in_d && op == 3'b010 |=> pc_high_latch == $past(hwdata[6:0]))
    else $error("latch literal not loaded");
  latch_hold_a: assert property (
    !(in_d && op == 3'b010) && !(wv_q && hready &&
    wa_q == dmx_pkg::OFS_PCLATCH) |=> $stable(pc_high_latch))
    else $error("pc high latch changed");
  option_hold_a: assert property (
    !(in_d && op == 3'b101) && !(wv_q && hready &&
    wa_q == dmx_pkg::OFS_OPTION) |=> $stable(option_cfg))
    else $error("option register changed");
  write_nowait_a: assert property (
    wv_q && ce |-> hreadyout)
    else $error("write data phase stalled");
  read_wait_a: assert property (
    tk && !hwrite |=> !hreadyout [*2] ##1 hreadyout)
    else $error("read wait states wrong");
  resp_okay_a: assert property (
    hresp == 1'b0)
    else $error("error response seen");
  cover property (in_d && op == 3'b110);
  cover property (in_d && op == 3'b111);
  cover property (tk && !hwrite);
  cover property (in_d && op == 3'b000);
endmodule
bind dmx_exec dmx_exec_checker dmx_exec_checker_i (.hclk, .hresetn,
  .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .bank_selector, .pc_high_latch, .option_cfg);
`default_nettype wire

// >>> tb/dmx_exec_test.sv
/*
  Self-checking bench for the data-move executor over AHB-Lite.
  Assumes one clock and this block as the only slave.
*/
`default_nettype none
module dmx_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [4:0]  bank_selector;
  logic [6:0]  pc_high_latch;
  logic [7:0]  option_cfg;
  logic [31:0] exp_q[$];
  logic [31:0] seed;
  logic        rp = 1'b0;
  logic [7:0]  k;
  logic [7:0]  pa;
  logic [5:0]  k6;
  logic [15:0] p;
  logic [15:0] ea;
  logic [15:0] np;
  int          bad_count;
  int          compares;
  int          n_ins;

  dmx_exec dmx_exec_i (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .bank_selector, .pc_high_latch, .option_cfg);

  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL %0t read %h expected %h", $time, s, e);
    end
  endtask

  task automatic report_and_stop;
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    if (w)
      hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic ins(input logic [2:0] op, input logic [10:0] f);
    n_ins++;
    xfer(1'b1, dmx_pkg::OFS_INSTR, {18'h0, op, f});
  endtask

  // Compares each completed read with the oldest expected value.
  always @(posedge hclk)
  begin
    if (rp && hreadyout === 1'b1)
    begin
      if (exp_q.size() > 0)
        check(hrdata, exp_q.pop_front());
      else
      begin
        bad_count++;
        $display("FAIL %0t read with nothing expected", $time);
      end
      rp = 1'b0;
    end
    if (hreadyout === 1'b1 && hsel && htrans[1] && !hwrite)
      rp = 1'b1;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    seed = 32'd78;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(dmx_pkg::OFS_OPTION, 32'hff);
    xfer(1'b1, dmx_pkg::OFS_STATUS, 32'ha5);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      k = (i == 0) ? 8'hff : seed[7:0];
      ins(3'b001, {6'h0, k[4:0]});
      ins(3'b010, {4'h0, k[6:0]});
      ins(3'b011, {3'h0, k});
      rd(dmx_pkg::OFS_BANK, {27'h0, k[4:0]});
      rd(dmx_pkg::OFS_PCLATCH, {25'h0, k[6:0]});
      rd(dmx_pkg::OFS_ACC, {24'h0, k});
      ins(3'b101, 11'h0);
      rd(dmx_pkg::OFS_OPTION, {24'h0, k});
      ins(3'b100, {5'h1, k[5:0]});
      xfer(1'b1, dmx_pkg::OFS_MEMADDR, {26'h1, k[5:0]});
      rd(dmx_pkg::OFS_MEMDATA, {24'h0, k});
    end
    for (int m = 0; m < 8; m++)
    begin
      pa = m[2] ? dmx_pkg::OFS_PTR1 : dmx_pkg::OFS_PTR0;
      p = m[0] ? 16'h0000 : 16'hffff;
      np = m[0] ? p - 16'h1 : p + 16'h1;
      ea = m[1] ? p : np;
      seed = xs(seed);
      ins(3'b011, {3'h0, seed[7:0]});
      xfer(1'b1, pa, {16'h0, p});
      ins(3'b110, {8'h0, m[2], m[1:0]});
      rd(dmx_pkg::OFS_EADDR, {16'h0, ea});
      rd(pa, {16'h0, np});
      xfer(1'b1, dmx_pkg::OFS_MEMADDR, {25'h0, ea[6:0]});
      rd(dmx_pkg::OFS_MEMDATA, {24'h0, seed[7:0]});
    end
    for (int m = 0; m < 4; m++)
    begin
      pa = m[0] ? dmx_pkg::OFS_PTR1 : dmx_pkg::OFS_PTR0;
      k6 = m[1] ? 6'h1f : 6'h20;
      p = 16'h0010;
      xfer(1'b1, pa, {16'h0, p});
      ins(3'b111, {4'h0, m[0], k6});
      ea = p + {{10{k6[5]}}, k6};
      rd(dmx_pkg::OFS_EADDR, {16'h0, ea});
      rd(pa, {16'h0, p});
    end
    xfer(1'b1, dmx_pkg::OFS_PTR1, 32'h0155);
    ins(3'b011, 11'h03c);
    ins(3'b100, 11'h001);
    rd(dmx_pkg::OFS_EADDR, 32'h0155);
    xfer(1'b1, dmx_pkg::OFS_MEMADDR, 32'h55);
    rd(dmx_pkg::OFS_MEMDATA, 32'h3c);
    rd(dmx_pkg::OFS_STATUS, 32'ha5);
    ins(3'b000, 11'h7ff);
    rd(dmx_pkg::OFS_ICOUNT, 32'(n_ins));
    rd(8'h40, 32'h0);
    repeat (4) @(posedge hclk);
    report_and_stop();
  end
endmodule
`default_nettype wire
